// ===== design/codec_status_pkg.sv
// package: register map, field positions and types of the codec status flag bank
package codec_status_pkg;

  localparam logic [7:0] ADDR_MODULE_POWER_STATE = 8'h5e;
  localparam logic [7:0] ADDR_DRIVER_SHORT_POWER = 8'h5f;
  localparam logic [7:0] ADDR_LATCHED_EVENT      = 8'h60;
  localparam logic [7:0] ADDR_LIVE_EVENT         = 8'h61;

  localparam logic [7:0] RESET_STATUS = 8'h00;

  // field positions
  localparam int POS_DAC_LEFT   = 7;
  localparam int POS_DAC_RIGHT  = 6;
  localparam int POS_MONO_LINE  = 5;
  localparam int POS_LEFT_LINE  = 4;
  localparam int POS_RIGHT_LINE = 3;
  localparam int POS_HP_LEFT    = 2;
  localparam int POS_HP_RIGHT   = 1;
  localparam int POS_SHORT_LSB  = 4;
  localparam int POS_COM_LEFT   = 3;
  localparam int POS_COM_RIGHT  = 2;
  localparam int POS_BUTTON     = 3;
  localparam int POS_HEADSET    = 2;
  localparam int POS_AGC_LEFT   = 1;
  localparam int POS_AGC_RIGHT  = 0;

  localparam int NUM_EVENTS = 8;

  // continuous interrupt pulse train: 2 ms high / 2 ms low at 250 MHz
  localparam int PULSE_PERIOD_NS = 2000000;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int PULSE_CYCLES    = PULSE_PERIOD_NS / CLK_PERIOD_NS;

  // short order: headphone left main, right main, left common, right common
  typedef struct packed {
    logic headphone_left_main;
    logic headphone_right_main;
    logic headphone_left_common;
    logic headphone_right_common;
  } short_t;

  typedef struct packed {
    logic dac_left;
    logic dac_right;
    logic mono_line_output;
    logic left_line_output;
    logic right_line_output;
    logic headphone_left_main;
    logic headphone_right_main;
    logic headphone_left_common;
    logic headphone_right_common;
  } power_t;

  typedef struct packed {
    logic button_press;
    logic headset_change;
    logic agc_left_noise;
    logic agc_right_noise;
  } misc_event_t;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_HIGH = 2'b01,
    PULSE_LOW  = 2'b10
  } pulse_state_t;

endpackage

// ===== design/sticky_flag.sv
// sticky flag: set by an event, cleared by a read acknowledge, set wins over clear
`timescale 1ns/1ps
module sticky_flag
  import codec_status_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_set) begin
        o_flag <= 1'b1;
      end else if (i_clear) begin
        o_flag <= 1'b0;
      end
    end
  end

endmodule

// ===== design/codec_status_flag_registers.sv
// codec status flag registers: power, short-circuit, sticky and live event flags
`timescale 1ns/1ps
module codec_status_flag_registers
  import codec_status_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ce,
  input  wire power_t      i_power,
  input  wire short_t      i_short,
  input  wire misc_event_t i_misc,
  input  wire logic        i_continuous,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  output logic             o_irq
);

  logic [7:0]        module_power_state;
  logic [7:0]        driver_short_and_power_state;
  logic [7:0]        latched_event_flags;
  logic [7:0]        live_event_flags;
  logic [7:0]        event_in;
  logic [7:0]        event_prev;
  logic [7:0]        event_rise;
  logic              ack_read;
  logic              any_rise;
  logic [31:0]       pulse_cnt;
  pulse_state_t      pulse_state;
  pulse_state_t      next_pulse_state;
  logic [7:0]        next_rdata;

  // one-shot mode gives a single pulse; continuous mode repeats until acknowledged
  assign ack_read = i_rd && (i_addr == ADDR_LATCHED_EVENT);

  // status snapshots, registered from the detector levels
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      module_power_state           <= RESET_STATUS;
      driver_short_and_power_state <= RESET_STATUS;
      live_event_flags             <= RESET_STATUS;
    end else if (i_ce) begin
      module_power_state[POS_DAC_LEFT]   <= i_power.dac_left;
      module_power_state[POS_DAC_RIGHT]  <= i_power.dac_right;
      module_power_state[POS_MONO_LINE]  <= i_power.mono_line_output;
      module_power_state[POS_LEFT_LINE]  <= i_power.left_line_output;
      module_power_state[POS_RIGHT_LINE] <= i_power.right_line_output;
      module_power_state[POS_HP_LEFT]    <= i_power.headphone_left_main;
      module_power_state[POS_HP_RIGHT]   <= i_power.headphone_right_main;
      module_power_state[0]              <= 1'b0;
      driver_short_and_power_state[7:POS_SHORT_LSB] <= i_short;
      driver_short_and_power_state[POS_COM_LEFT]  <= i_power.headphone_left_common;
      driver_short_and_power_state[POS_COM_RIGHT] <= i_power.headphone_right_common;
      driver_short_and_power_state[1:0] <= 2'b00;
      live_event_flags <= {i_short, 4'h0};
    end
  end

  assign event_in = {i_short, i_misc};

  // sticky bits set on the rising edge of each source
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      event_prev <= RESET_STATUS;
    end else if (i_ce) begin
      event_prev <= event_in;
    end
  end

  assign event_rise = event_in & ~event_prev;
  assign any_rise   = |event_rise;

  genvar g;
  generate
    for (g = 0; g < NUM_EVENTS; g++) begin : g_sticky
      sticky_flag u_flag (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_ce    (i_ce),
        .i_set   (event_rise[g]),
        .i_clear (ack_read),
        .o_flag  (latched_event_flags[g])
      );
    end
  endgenerate

  // read port: writes are accepted and ignored
  always_comb begin
    next_rdata = 8'h00;
    case (i_addr)
      ADDR_MODULE_POWER_STATE: next_rdata = module_power_state;
      ADDR_DRIVER_SHORT_POWER: next_rdata = driver_short_and_power_state;
      ADDR_LATCHED_EVENT:      next_rdata = latched_event_flags;
      ADDR_LIVE_EVENT:         next_rdata = live_event_flags;
      default:                 next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= next_rdata;
      end
    end
  end

  // interrupt pulse generator
  always_comb begin
    next_pulse_state = pulse_state;
    case (pulse_state)
      PULSE_IDLE: begin
        if (any_rise) begin
          next_pulse_state = PULSE_HIGH;
        end
      end
      PULSE_HIGH: begin
        if (i_continuous && ack_read) begin
          next_pulse_state = PULSE_IDLE;
        end else if (pulse_cnt == 32'(PULSE_LEN - 1)) begin
          next_pulse_state = i_continuous ? PULSE_LOW : PULSE_IDLE;
        end
      end
      PULSE_LOW: begin
        if (ack_read) begin
          next_pulse_state = PULSE_IDLE;
        end else if (pulse_cnt == 32'(PULSE_LEN - 1)) begin
          next_pulse_state = PULSE_HIGH;
        end
      end
      default: next_pulse_state = PULSE_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pulse_state <= PULSE_IDLE;
      pulse_cnt   <= 32'h0000_0000;
      o_irq       <= 1'b0;
    end else if (i_ce) begin
      pulse_state <= next_pulse_state;
      o_irq       <= (next_pulse_state == PULSE_HIGH);
      if (next_pulse_state != pulse_state) begin
        pulse_cnt <= 32'h0000_0000;
      end else begin
        pulse_cnt <= pulse_cnt + 32'h0000_0001;
      end
    end
  end

  // assertion helper: length of the current interrupt high run
  logic [31:0] irq_run;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_run <= 32'h0000_0000;
    end else if (i_ce) begin
      if (o_irq) begin
        irq_run <= irq_run + 32'h0000_0001;
      end else begin
        irq_run <= 32'h0000_0000;
      end
    end
  end

  // status registers follow their detector levels one cycle later
  a_power_dac_left: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce |=> module_power_state[POS_DAC_LEFT] == $past(i_power.dac_left))
    else $error("left dac power bit wrong");
  a_power_dac_right: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce |=> module_power_state[POS_DAC_RIGHT] == $past(i_power.dac_right))
    else $error("right dac power bit wrong");
  a_line_outputs: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce |=> module_power_state[5:3] == $past({i_power.mono_line_output,
      i_power.left_line_output, i_power.right_line_output}))
    else $error("line output power bits wrong");
  a_headphone_main_power: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce |=> module_power_state[2:1] == $past({i_power.headphone_left_main,
      i_power.headphone_right_main}))
    else $error("main headphone power bits wrong");
  a_common_power: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce |=> driver_short_and_power_state[3:2] == $past({i_power.headphone_left_common,
      i_power.headphone_right_common}))
    else $error("common driver power bits wrong");
  a_reserved_zero: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    module_power_state[0] == 1'b0 && driver_short_and_power_state[1:0] == 2'b00)
    else $error("reserved bits not zero");
  a_short_mirror: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce |=> driver_short_and_power_state[7:4] == $past(i_short)
      && live_event_flags[7:4] == $past(i_short))
    else $error("short state mismatch");

  // sticky flags: set on an event, held until the acknowledging read
  a_sticky_sets: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && any_rise) |=> (latched_event_flags & $past(event_rise)) == $past(event_rise))
    else $error("event not latched");
  a_sticky_holds: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && !ack_read) |=> (latched_event_flags & $past(latched_event_flags))
      == $past(latched_event_flags))
    else $error("sticky flag dropped without a read");
  a_sticky_no_event: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && !any_rise) |=> (latched_event_flags & ~$past(latched_event_flags)) == 8'h00)
    else $error("sticky flag set without an event");
  a_sticky_clear: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && ack_read && !any_rise) |=> latched_event_flags == 8'h00)
    else $error("read did not clear sticky flags");
  a_write_ignored: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_wr && !i_rd) |=> latched_event_flags
      == ($past(latched_event_flags) | $past(event_rise)))
    else $error("write changed sticky flags");

  // read port answers one cycle after the strobe
  a_read_power: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rd && i_addr == ADDR_MODULE_POWER_STATE) |=> o_rvalid
      && o_rdata == $past(module_power_state))
    else $error("power status read wrong");
  a_read_latched: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rd && i_addr == ADDR_LATCHED_EVENT) |=> o_rvalid
      && o_rdata == $past(latched_event_flags))
    else $error("sticky flag read wrong");
  a_read_data: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rd && i_addr == ADDR_LIVE_EVENT) |=> o_rdata[3:0] == 4'h0 && o_rvalid)
    else $error("live register low nibble nonzero");
  a_read_unmapped: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rd && (i_addr < ADDR_MODULE_POWER_STATE || i_addr > ADDR_LIVE_EVENT))
      |=> o_rdata == 8'h00)
    else $error("unmapped address read nonzero");

  // interrupt pulse timing
  a_irq_starts: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && any_rise && pulse_state == PULSE_IDLE) |=> o_irq)
    else $error("event did not raise the interrupt");
  a_irq_single_ends: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && !i_continuous && pulse_state == PULSE_HIGH
      && pulse_cnt == 32'(PULSE_LEN - 1)) |=> !o_irq)
    else $error("single interrupt pulse did not end");
  a_irq_train_repeats: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && !ack_read && pulse_state == PULSE_LOW
      && pulse_cnt == 32'(PULSE_LEN - 1)) |=> o_irq)
    else $error("interrupt train did not repeat");
  a_irq_ack_stops: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && ack_read && !any_rise && pulse_state == PULSE_LOW)
      |=> !o_irq)
    else $error("interrupt continued after acknowledge");
  a_irq_ack_high: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_continuous && ack_read && pulse_state == PULSE_HIGH)
      |=> !o_irq)
    else $error("interrupt pulse continued after acknowledge");
  a_irq_run_bound: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_irq |-> irq_run < 32'(PULSE_LEN))
    else $error("interrupt pulse too long");
  a_irq_run_full: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    ($fell(o_irq) && !i_continuous) |-> irq_run == 32'(PULSE_LEN))
    else $error("single interrupt pulse too short");

  c_event_latched: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    any_rise ##1 latched_event_flags != 8'h00);
  c_ack_read: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    latched_event_flags != 8'h00 ##1 ack_read);
  c_continuous: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    pulse_state == PULSE_LOW ##1 pulse_state == PULSE_HIGH);
  c_write_ignored: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    i_wr && i_addr == ADDR_LATCHED_EVENT);
  c_ack_in_high: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    pulse_state == PULSE_HIGH && i_continuous && ack_read);

endmodule

// ===== testbench/test_codec_status_flag_registers.sv
// testbench: self-checking scenarios for the codec status flag registers
`timescale 1ns/1ps
module test_codec_status_flag_registers
  import codec_status_pkg::*;
;
  localparam int PLEN = 4;
  logic        clk;
  logic        rst_b;
  logic        ce;
  power_t      power;
  short_t      short_in;
  misc_event_t misc;
  logic        continuous;
  logic        rd;
  logic        wr;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        irq;
  int          failures;
  int          cmp_count;

  codec_status_flag_registers #(.PULSE_LEN(PLEN)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_power(power), .i_short(short_in),
    .i_misc(misc), .i_continuous(continuous), .i_rd(rd), .i_wr(wr), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report();
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one read strobe, then a bounded wait for the answer
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    while (rvalid !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    chk("rvalid", 8'h01, {7'h00, rvalid});
    d = rdata;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic count_irq(input int cyc, output int hi);
    hi = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (irq === 1'b1) hi++;
    end
  endtask

  task automatic t_reset();
    for (int a = 8'h5e; a <= 8'h62; a++) expect_reg(8'(a), 8'h00);
  endtask

  task automatic t_power();
    logic [8:0] p;
    for (int i = 0; i <= 9; i++) begin
      p = (i == 9) ? 9'h1ff : 9'h001 << i;
      power = p;
      idle(2);
      expect_reg(ADDR_MODULE_POWER_STATE, {p[8:2], 1'b0});
      expect_reg(ADDR_DRIVER_SHORT_POWER, {4'h0, p[1:0], 2'b00});
    end
    wr_reg(ADDR_MODULE_POWER_STATE, 8'h00);
    wr_reg(ADDR_DRIVER_SHORT_POWER, 8'hf0);
    wr_reg(ADDR_LATCHED_EVENT, 8'hff);
    expect_reg(ADDR_MODULE_POWER_STATE, 8'hfe);
    expect_reg(ADDR_DRIVER_SHORT_POWER, 8'h0c);
    expect_reg(ADDR_LATCHED_EVENT, 8'h00);
    power = '0;
  endtask

  task automatic t_short();
    logic [3:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 4'h8 >> i;
      short_in = s;
      idle(2);
      expect_reg(ADDR_LIVE_EVENT, {s, 4'h0});
      expect_reg(ADDR_DRIVER_SHORT_POWER, {s, 4'h0});
      short_in = '0;
      idle(PLEN + 3);
      expect_reg(ADDR_LIVE_EVENT, 8'h00);
      expect_reg(ADDR_LATCHED_EVENT, {s, 4'h0});
      expect_reg(ADDR_LATCHED_EVENT, 8'h00);
    end
  endtask

  task automatic t_misc();
    logic [3:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 4'h8 >> i;
      misc = m;
      idle(PLEN + 3);
      misc = '0;
      expect_reg(ADDR_LATCHED_EVENT, {4'h0, m});
      expect_reg(ADDR_LIVE_EVENT, 8'h00);
    end
  endtask

  task automatic t_irq();
    int hi;
    logic [7:0] d;
    misc = 4'h8;
    count_irq(3 * PLEN, hi);
    chk("single pulse length", 8'(PLEN), 8'(hi));
    rd_reg(ADDR_LATCHED_EVENT, d);
    misc = '0;
    continuous = 1'b1;
    short_in = 4'h2;
    count_irq(4 * PLEN - 2, hi);
    chk("pulse train continues", 8'h01, {7'h00, hi > PLEN});
    rd_reg(ADDR_LATCHED_EVENT, d);
    chk("latched flags", 8'h20, d);
    idle(1);
    count_irq(3 * PLEN, hi);
    chk("irq stopped by read", 8'h00, 8'(hi));
    short_in = 4'h1;
    count_irq(4 * PLEN + 2, hi);
    rd_reg(ADDR_LATCHED_EVENT, d);
    chk("latched flags", 8'h10, d);
    count_irq(3 * PLEN, hi);
    chk("irq stopped in high phase", 8'h00, 8'(hi));
    continuous = 1'b0;
    short_in = '0;
    idle(PLEN + 2);
  endtask

  task automatic t_mid_reset();
    misc = 4'hf;
    short_in = 4'hf;
    idle(2);
    rst_b = 1'b0;
    idle(2);
    chk("irq in reset", 8'h00, {7'h00, irq});
    misc = '0;
    short_in = '0;
    rst_b = 1'b1;
    t_reset();
  endtask

  initial begin
    #20000;
    failures++;
    final_report();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    power = '0;
    short_in = '0;
    misc = '0;
    continuous = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_power();
    t_short();
    t_misc();
    t_irq();
    t_mid_reset();
    final_report();
  end
endmodule
